// ==== shared/osc_ctrl_pkg.sv ====
// oscillator control and power-mode package: register map, fields, resets, types
// assumes a 32-bit avalon-mm slave with byte addresses on a 4-bit address port
package osc_ctrl_pkg;
    // ========================================
    // register map
    localparam logic [3:0] SYS_CLK_OFS   = 4'h0;
    localparam logic [3:0] FAST_OSC_OFS  = 4'h4;
    localparam logic [3:0] CRYSTAL_OFS   = 4'h8;
    localparam logic [3:0] STATUS_OFS    = 4'hc;
    // ========================================
    // reset values
    localparam logic [7:0] SYS_CLK_RST   = 8'he0;
    localparam logic [7:0] FAST_OSC_RST  = 8'h00;
    localparam logic [7:0] CRYSTAL_RST   = 8'h00;
    // ========================================
    // field positions
    localparam int SEL_LSB      = 5;
    localparam int SUB_SRC_BIT  = 2;
    localparam int FAST_KEEP    = 1;
    localparam int SUB_KEEP     = 0;
    localparam int FREQ_LSB     = 2;
    localparam int STABLE_BIT   = 1;
    localparam int ENABLE_BIT   = 0;
    localparam int SPEEDUP_BIT  = 2;
    localparam int PDF_BIT      = 0;
    localparam int WDT_TO_BIT   = 1;
    localparam int ON_SUB_BIT   = 2;
    localparam int MODE_LSB     = 4;
    // ========================================
    // codes and timing
    localparam logic [2:0] SEL_SUB      = 3'h7;
    localparam logic [1:0] FREQ_CODE_4M = 2'h1;
    localparam logic [1:0] FREQ_CODE_8M = 2'h2;
    localparam logic [3:0] MHZ_2        = 4'h2;
    localparam logic [3:0] MHZ_4        = 4'h4;
    localparam logic [3:0] MHZ_8        = 4'h8;
    localparam int         BLANK_CYCLES = 4;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0] {
        PM_RUN       = 3'h0,
        PM_SLEEP     = 3'h1,
        PM_IDLE_SUB  = 3'h2,
        PM_IDLE_BOTH = 3'h3,
        PM_IDLE_FAST = 3'h4
    } power_mode_t;

    typedef struct packed {
        logic fastReady;
        logic crystalReady;
        logic slowRcReady;
    } osc_ready_t;

    typedef struct packed {
        logic       fastOscRun;
        logic       crystalRun;
        logic       crystalSpeedup;
        logic [3:0] fastFreqMhz;
        logic       sysOnSub;
        logic       subIsCrystal;
        logic [2:0] fastDivCode;
        logic       cpuRun;
        logic       fastClockOn;
        logic       subClockOn;
    } clk_ctrl_t;
endpackage

// ==== src/osc_ctrl_power_mode_switch.sv ====
// oscillator enables, stable flags, fast/slow clock switch and halt power modes
// assumes oscillator ready levels arrive from analog pins, halt and watchdog
// strobes come from the cpu core on clk
`timescale 1ns/1ns

// Operation
// - frequency code 00/11 gives 2 MHz, 01 gives 4 MHz, 10 gives 8 MHz
// - new fast frequency is applied only once the fast stable flag is set
// - fast stable flag clears on enable or frequency change, sets when stable
// - fast control bit 0 turns the fast oscillator on or off only while the system runs on the sub clock
// - crystal control bit 2 selects crystal speed-up operation
// - speed-up bit is frozen while the crystal drives the system clock
// - crystal stable flag clears on enable, sets once the crystal is stable
// - crystal control bit 0 turns the crystal on or off
// - select 111 in fast mode moves the system clock to the sub clock
// - sub clock source follows source bit; switch waits for that oscillator
// - select 000..110 in slow mode returns to fast clock divided 1..64
// - halt with both keep bits 0 enters sleep, all clocks stopped
// - halt with fast keep 0, sub keep 1 keeps only the sub clock
// - halt with both keep bits 1 keeps fast and sub clocks running
// - halt with fast keep 1, sub keep 0 keeps only the fast clock
// - any halt mode stops the cpu and holds the fast/slow clock switch state
// - any halt mode sets power-down flag and clears watchdog timeout flag unless a timeout arrives in the entry cycle
// - any halt mode clears the watchdog counter, which keeps counting
// - sub source bit 0 picks slow rc oscillator, 1 picks the crystal
// - keep bits decide which clocks run after halt; the crystal follows its enable bit
module osc_ctrl_power_mode_switch
    import osc_ctrl_pkg::*;
#(
    parameter int BLANK = BLANK_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic [3:0]               address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    input  wire logic [3:0]               byteenable,
    output logic [31:0]                   readdata,
    output logic                          waitrequest,
    output logic [1:0]                    response,
    input  wire logic                     haltExec,
    input  wire logic                     wakeUp,
    input  wire logic                     wdtClearInstr,
    input  wire logic                     wdtTimeout,
    input  wire osc_ctrl_pkg::osc_ready_t oscReady,
    output osc_ctrl_pkg::clk_ctrl_t       clkCtrl,
    output logic                          wdtCounterClear
);
    import osc_ctrl_pkg::*;

    // elaboration-time guard: the blanking counter is eight bits and its load value is never zero
    if (BLANK < 1 || BLANK > 255) begin : g_badBlank
        $error("BLANK must lie in 1..255");
    end

    // ========================================
    // input synchronisers
    osc_ready_t  readyMeta_reg;
    osc_ready_t  readySync_reg;
    logic        wakeMeta_reg;
    logic        wakeSync_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            readyMeta_reg <= '0;
            readySync_reg <= '0;
            wakeMeta_reg  <= 1'b0;
            wakeSync_reg  <= 1'b0;
        end else begin
            readyMeta_reg <= oscReady;
            readySync_reg <= readyMeta_reg;
            wakeMeta_reg  <= wakeUp;
            wakeSync_reg  <= wakeMeta_reg;
        end
    end

    // ========================================
    // avalon slave handshake
    // one wait cycle: the write lands on the edge that samples waitrequest low
    logic        access;
    logic        wrDone;
    logic        mapped;

    assign access = (read || write) && waitrequest;
    assign wrDone = write && !waitrequest && byteenable[0];
    assign mapped = (address == SYS_CLK_OFS) || (address == FAST_OSC_OFS)
                 || (address == CRYSTAL_OFS) || (address == STATUS_OFS);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !access;
        end
    end

    // ========================================
    // control registers
    logic [7:0]  sysClk_reg;
    logic        fastEn_reg;
    logic [1:0]  fastFreq_reg;
    logic        crysEn_reg;
    logic        speedup_reg;
    logic        sysOnSub_reg;
    logic        wrSys;
    logic        wrFast;
    logic        wrCrys;

    assign wrSys  = wrDone && (address == SYS_CLK_OFS);
    assign wrFast = wrDone && (address == FAST_OSC_OFS);
    assign wrCrys = wrDone && (address == CRYSTAL_OFS);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sysClk_reg <= SYS_CLK_RST;
        end else if (wrSys) begin
            sysClk_reg <= writedata[7:0] & 8'he7;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fastEn_reg   <= FAST_OSC_RST[ENABLE_BIT];
            fastFreq_reg <= FAST_OSC_RST[FREQ_LSB +: 2];
        end else if (wrFast) begin
            fastEn_reg   <= writedata[ENABLE_BIT];
            fastFreq_reg <= writedata[FREQ_LSB +: 2];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crysEn_reg  <= CRYSTAL_RST[ENABLE_BIT];
            speedup_reg <= CRYSTAL_RST[SPEEDUP_BIT];
        end else if (wrCrys) begin
            crysEn_reg <= writedata[ENABLE_BIT];
            // frozen while the crystal is the running system clock
            if (!(sysOnSub_reg && sysClk_reg[SUB_SRC_BIT])) begin
                speedup_reg <= writedata[SPEEDUP_BIT];
            end
        end
    end

    // ========================================
    // stable flags
    // the blanking window hides a stale ready level still in the synchroniser
    logic        fastEvent;
    logic        crysEvent;
    logic        fastStable_reg;
    logic        crysStable_reg;
    logic [7:0]  fastBlank_reg;
    logic [7:0]  crysBlank_reg;

    assign fastEvent = wrFast && writedata[ENABLE_BIT]
                    && (!fastEn_reg || writedata[FREQ_LSB +: 2] != fastFreq_reg);
    assign crysEvent = wrCrys && writedata[ENABLE_BIT] && !crysEn_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fastStable_reg <= 1'b0;
            fastBlank_reg  <= 8'h00;
        end else if (fastEvent) begin
            fastStable_reg <= 1'b0;
            fastBlank_reg  <= 8'(BLANK);
        end else if (fastBlank_reg != 8'h00) begin
            fastBlank_reg  <= fastBlank_reg - 8'h01;
        end else begin
            fastStable_reg <= fastEn_reg && readySync_reg.fastReady;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crysStable_reg <= 1'b0;
            crysBlank_reg  <= 8'h00;
        end else if (crysEvent) begin
            crysStable_reg <= 1'b0;
            crysBlank_reg  <= 8'(BLANK);
        end else if (crysBlank_reg != 8'h00) begin
            crysBlank_reg  <= crysBlank_reg - 8'h01;
        end else begin
            crysStable_reg <= crysEn_reg && readySync_reg.crystalReady;
        end
    end

    // ========================================
    // applied fast frequency
    logic [3:0]  freqMhz;
    logic [3:0]  appliedMhz_reg;

    always_comb begin
        case (fastFreq_reg)
            FREQ_CODE_4M: freqMhz = MHZ_4;
            FREQ_CODE_8M: freqMhz = MHZ_8;
            default:      freqMhz = MHZ_2;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            appliedMhz_reg <= MHZ_2;
        end else if (fastStable_reg) begin
            appliedMhz_reg <= freqMhz;
        end
    end

    // ========================================
    // fast / slow system clock switch
    logic        subSource;
    logic        subStable;
    logic        selSub;

    assign subSource = sysClk_reg[SUB_SRC_BIT];
    assign subStable = subSource ? crysStable_reg : readySync_reg.slowRcReady;
    assign selSub    = sysClk_reg[SEL_LSB +: 3] == SEL_SUB;

    power_mode_t mode_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sysOnSub_reg <= 1'b0;
        end else if (mode_reg == PM_RUN) begin
            if (!sysOnSub_reg && selSub && subStable) begin
                sysOnSub_reg <= 1'b1;
            end else if (sysOnSub_reg && !selSub) begin
                // no wait on the fast flag: software polls it on return
                sysOnSub_reg <= 1'b0;
            end
        end
    end

    // ========================================
    // halt power modes
    logic        enterHalt;
    power_mode_t haltMode;

    assign enterHalt = haltExec && (mode_reg == PM_RUN);

    always_comb begin
        case ({sysClk_reg[FAST_KEEP], sysClk_reg[SUB_KEEP]})
            2'b01:   haltMode = PM_IDLE_SUB;
            2'b11:   haltMode = PM_IDLE_BOTH;
            2'b10:   haltMode = PM_IDLE_FAST;
            default: haltMode = PM_SLEEP;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= PM_RUN;
        end else begin
            case (mode_reg)
                PM_RUN:  if (enterHalt) mode_reg <= haltMode;
                default: if (wakeSync_reg) mode_reg <= PM_RUN;
            endcase
        end
    end

    // ========================================
    // status flags and watchdog clear
    logic        pdf_reg;
    logic        wdtTo_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pdf_reg <= 1'b0;
        end else if (enterHalt) begin
            pdf_reg <= 1'b1;
        end else if (wdtClearInstr) begin
            pdf_reg <= 1'b0;
        end
    end

    // a timeout in the entry cycle still wins so the event is never lost
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdtTo_reg <= 1'b0;
        end else if (wdtTimeout) begin
            wdtTo_reg <= 1'b1;
        end else if (enterHalt) begin
            wdtTo_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdtCounterClear <= 1'b0;
        end else begin
            wdtCounterClear <= enterHalt;
        end
    end

    // ========================================
    // clock control outputs
    clk_ctrl_t   ctrlNext;
    logic        running;

    assign running = (mode_reg == PM_RUN);

    always_comb begin
        ctrlNext                = '0;
        ctrlNext.fastOscRun     = running ? (fastEn_reg || !sysOnSub_reg)
                                : (mode_reg == PM_IDLE_BOTH || mode_reg == PM_IDLE_FAST);
        ctrlNext.crystalRun     = crysEn_reg;
        ctrlNext.crystalSpeedup = speedup_reg;
        ctrlNext.fastFreqMhz    = appliedMhz_reg;
        ctrlNext.sysOnSub       = sysOnSub_reg;
        ctrlNext.subIsCrystal   = subSource;
        ctrlNext.fastDivCode    = sysOnSub_reg ? 3'h0 : sysClk_reg[SEL_LSB +: 3];
        ctrlNext.cpuRun         = running;
        ctrlNext.fastClockOn    = ctrlNext.fastOscRun && (mode_reg != PM_SLEEP);
        ctrlNext.subClockOn     = running || mode_reg == PM_IDLE_SUB
                                || mode_reg == PM_IDLE_BOTH;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clkCtrl <= '0;
        end else begin
            clkCtrl <= ctrlNext;
        end
    end

    // ========================================
    // read path
    logic [7:0]  rdByte;

    always_comb begin
        case (address)
            SYS_CLK_OFS:  rdByte = sysClk_reg;
            FAST_OSC_OFS: rdByte = {4'h0, fastFreq_reg, fastStable_reg, fastEn_reg};
            CRYSTAL_OFS:  rdByte = {5'h00, speedup_reg, crysStable_reg, crysEn_reg};
            STATUS_OFS:   rdByte = {1'b0, mode_reg, 1'b0, sysOnSub_reg, wdtTo_reg, pdf_reg};
            default:      rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
            response <= RESP_OKAY;
        end else if (access) begin
            readdata <= read ? {24'h000000, rdByte} : 32'h0000_0000;
            response <= mapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_freqMap;
        fastStable_reg && fastFreq_reg == 2'h3 |=> appliedMhz_reg == 4'h2;
    endproperty
    a_freqMap: assert property (p_freqMap) else $error("freq code 3 not 2 MHz");

    property p_applyOnStable;
        !fastStable_reg |=> $stable(appliedMhz_reg);
    endproperty
    a_applyOnStable: assert property (p_applyOnStable) else $error("freq applied early");

    property p_fastFlagClear;
        fastEvent |=> !fastStable_reg [*2];
    endproperty
    a_fastFlagClear: assert property (p_fastFlagClear) else $error("fast flag not cleared");

    property p_speedupFrozen;
        sysOnSub_reg && subSource && $past(sysOnSub_reg) |-> $stable(speedup_reg);
    endproperty
    a_speedupFrozen: assert property (p_speedupFrozen) else $error("speed-up changed");

    property p_crysFlagClear;
        crysEvent |=> !crysStable_reg;
    endproperty
    a_crysFlagClear: assert property (p_crysFlagClear) else $error("crystal flag kept");

    property p_slowNeedsStable;
        !sysOnSub_reg ##1 sysOnSub_reg |-> $past(subStable);
    endproperty
    a_slowNeedsStable: assert property (p_slowNeedsStable) else $error("switch before stable");

    property p_haltMode;
        enterHalt |=> mode_reg == $past(haltMode) ##1 !clkCtrl.cpuRun;
    endproperty
    a_haltMode: assert property (p_haltMode) else $error("wrong halt mode");

    property p_sleepClocks;
        mode_reg == PM_SLEEP |=> !clkCtrl.fastClockOn && !clkCtrl.subClockOn;
    endproperty
    a_sleepClocks: assert property (p_sleepClocks) else $error("clock on in sleep");

    property p_flagsOnHalt;
        enterHalt && !wdtTimeout |=> pdf_reg && !wdtTo_reg;
    endproperty
    a_flagsOnHalt: assert property (p_flagsOnHalt) else $error("halt flags wrong");

    property p_wdtClear;
        enterHalt |=> wdtCounterClear ##1 !wdtCounterClear;
    endproperty
    a_wdtClear: assert property (p_wdtClear) else $error("watchdog clear missing");
endmodule

// ==== bench/osc_ctrl_power_mode_switch_test.sv ====
// self-checking bench for the oscillator control and power-mode block
// assumes osc_ctrl_pkg is compiled first; the bench drives every port itself
`timescale 1ns/1ns
module osc_ctrl_power_mode_switch_test;
    import osc_ctrl_pkg::*;
    // ========================================
    // signals
    localparam int BLANK_TB = 1;
    logic        clk;
    logic        nrst;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
    logic        haltExec;
    logic        wakeUp;
    logic        wdtClearInstr;
    logic        wdtTimeout;
    osc_ready_t  oscReady;
    clk_ctrl_t   clkCtrl;
    logic        wdtCounterClear;
    logic [7:0]  rd;
    logic [7:0]  fastExp;
    logic [3:0]  prevMhz;
    logic [31:0] rnd;
    integer      seed;
    int          fail_count;
    int          checks_done;
    int          cycles;
    int          pulses;

    osc_ctrl_power_mode_switch #(.BLANK(BLANK_TB)) dut (
        .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .haltExec(haltExec),
        .wakeUp(wakeUp), .wdtClearInstr(wdtClearInstr), .wdtTimeout(wdtTimeout),
        .oscReady(oscReady), .clkCtrl(clkCtrl), .wdtCounterClear(wdtCounterClear)
    );

    // ========================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // whole run needs under a thousand cycles; this leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ========================================
    // expectations
    function automatic logic [3:0] freqOf(input logic [1:0] c);
        return (c == FREQ_CODE_4M) ? MHZ_4 : (c == FREQ_CODE_8M) ? MHZ_8 : MHZ_2;
    endfunction

    function automatic logic [2:0] modeOf(input logic [1:0] keep);
        case (keep)
            2'h0: return PM_SLEEP;
            2'h1: return PM_IDLE_SUB;
            2'h3: return PM_IDLE_BOTH;
            default: return PM_IDLE_FAST;
        endcase
    endfunction

    // stable flag follows enable once the oscillator reports ready
    function automatic logic [7:0] fastRead(input logic [7:0] d);
        return (d & 8'h0d) | {6'h00, d[0], 1'b0};
    endfunction

    // ========================================
    // tasks
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // one avalon transfer; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        logic [31:0] r;
        int          n;
        r = $random(seed);
        n = 0;
        @(posedge clk);
        address    <= a;
        writedata  <= {r[31:8], d};
        byteenable <= be;
        read       <= !wr;
        write      <= wr;
        // sampled at the rising edge; only the bench timeout ends a hung wait
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        check("wait cycles", 8'h02, 8'(n));
        check("response", (a[1:0] != 2'h0) ? 8'(RESP_SLVERR) : 8'(RESP_OKAY), 8'(response));
        if (!wr)
            check("readdata upper", 8'h00, 8'(|readdata[31:8]));
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rdChk(input string nm, input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'hf);
        check(nm, exp, rd);
    endtask

    // ========================================
    // main sequence
    initial begin
        seed = 32'hb9324425;
        nrst = 1'b0; address = 4'h0; read = 1'b0; write = 1'b0;
        writedata = 32'h0; byteenable = 4'h0; haltExec = 1'b0; wakeUp = 1'b0;
        wdtClearInstr = 1'b0; wdtTimeout = 1'b0; oscReady = '0;
        fail_count = 0; checks_done = 0; cycles = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rdChk("sys reset", SYS_CLK_OFS, SYS_CLK_RST);
        rdChk("fast reset", FAST_OSC_OFS, FAST_OSC_RST);
        rdChk("crystal reset", CRYSTAL_OFS, CRYSTAL_RST);
        rdChk("status reset", STATUS_OFS, 8'h00);
        rdChk("unmapped", 4'h2, 8'h00);
        wr(STATUS_OFS, 8'hff);
        rdChk("status read only", STATUS_OFS, 8'h00);
        check("on sub without source", 8'h00, 8'(clkCtrl.sysOnSub));
        // frequency codes, flag clearing and deferred application
        prevMhz = MHZ_2;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            oscReady.fastReady <= 1'b0;
            wr(FAST_OSC_OFS, {4'hf, c[1:0], 2'b11});
            cyc(8);
            rdChk("fast flag low", FAST_OSC_OFS, {4'h0, c[1:0], 2'b01});
            check("freq held", 8'(prevMhz), 8'(clkCtrl.fastFreqMhz));
            @(posedge clk);
            oscReady.fastReady <= 1'b1;
            cyc(8);
            rdChk("fast flag high", FAST_OSC_OFS, {4'h0, c[1:0], 2'b11});
            check("freq applied", 8'(freqOf(c[1:0])), 8'(clkCtrl.fastFreqMhz));
            check("fast running", 8'h01, 8'(clkCtrl.fastOscRun));
            prevMhz = freqOf(c[1:0]);
        end
        // random writes, some without the low byte lane
        fastExp = 8'h0f;
        for (int i = 0; i < 12; i++) begin
            rnd = $random(seed);
            bus(1'b1, FAST_OSC_OFS, rnd[7:0], rnd[11:8]);
            if (rnd[8])
                fastExp = fastRead(rnd[7:0]);
            cyc(6);
            rdChk("fast random", FAST_OSC_OFS, fastExp);
        end
        wr(FAST_OSC_OFS, 8'h01);
        // crystal, speed-up and slow switch
        wr(CRYSTAL_OFS, 8'hfd);
        cyc(6);
        rdChk("crystal unstable", CRYSTAL_OFS, 8'h05);
        check("crystal on", 8'h01, 8'(clkCtrl.crystalRun));
        check("speedup on", 8'h01, 8'(clkCtrl.crystalSpeedup));
        wr(SYS_CLK_OFS, 8'he4);
        cyc(8);
        check("waits for crystal", 8'h00, 8'(clkCtrl.sysOnSub));
        @(posedge clk);
        oscReady.crystalReady <= 1'b1;
        cyc(8);
        check("on sub", 8'h01, 8'(clkCtrl.sysOnSub));
        check("sub is crystal", 8'h01, 8'(clkCtrl.subIsCrystal));
        rdChk("crystal stable", CRYSTAL_OFS, 8'h07);
        wr(CRYSTAL_OFS, 8'h01);
        rdChk("speedup frozen", CRYSTAL_OFS, 8'h07);
        check("speedup kept", 8'h01, 8'(clkCtrl.crystalSpeedup));
        // every divider code back from slow mode
        for (int c = 0; c < 7; c++) begin
            wr(SYS_CLK_OFS, {c[2:0], 5'h04});
            cyc(4);
            check("back on fast", 8'h00, 8'(clkCtrl.sysOnSub));
            check("divider", 8'(c), 8'(clkCtrl.fastDivCode));
            wr(SYS_CLK_OFS, 8'he4);
            cyc(4);
            check("slow again", 8'h01, 8'(clkCtrl.sysOnSub));
        end
        // fast oscillator off in slow mode, then back to fast and poll its flag
        wr(FAST_OSC_OFS, 8'h00);
        cyc(4);
        check("fast off on sub", 8'h00, 8'(clkCtrl.fastOscRun));
        wr(SYS_CLK_OFS, 8'h04);
        wr(FAST_OSC_OFS, 8'h01);
        do bus(1'b0, FAST_OSC_OFS, 8'h00, 4'hf); while (rd[1] !== 1'b1);
        check("fast forced on", 8'h01, 8'(clkCtrl.fastOscRun));
        @(posedge clk);
        oscReady.slowRcReady <= 1'b1;
        wr(SYS_CLK_OFS, 8'he0);
        cyc(8);
        check("sub is slow rc", 8'h00, 8'(clkCtrl.subIsCrystal));
        check("on slow rc", 8'h01, 8'(clkCtrl.sysOnSub));
        // halt into each mode chosen by the keep bits
        for (int k = 0; k < 4; k++) begin
            wr(SYS_CLK_OFS, {5'h18, 1'b0, k[1:0]});
            cyc(4);
            rdChk("sys keep", SYS_CLK_OFS, {5'h18, 1'b0, k[1:0]});
            @(posedge clk);
            wdtTimeout <= 1'b1;
            @(posedge clk);
            wdtTimeout <= 1'b0;
            cyc(4);
            rdChk("timeout set", STATUS_OFS, 8'h02);
            @(posedge clk);
            haltExec <= 1'b1;
            @(posedge clk);
            haltExec <= 1'b0;
            pulses = 0;
            repeat (6) begin
                @(negedge clk);
                if (wdtCounterClear === 1'b1)
                    pulses++;
            end
            check("counter clear pulses", 8'h01, 8'(pulses));
            rdChk("halt status", STATUS_OFS, {1'b0, modeOf(k[1:0]), 4'h1});
            check("cpu stopped", 8'h00, 8'(clkCtrl.cpuRun));
            check("fast kept", 8'(k[1]), 8'(clkCtrl.fastClockOn));
            check("sub kept", 8'(k[0]), 8'(clkCtrl.subClockOn));
            @(posedge clk);
            haltExec <= 1'b1;
            @(posedge clk);
            haltExec <= 1'b0;
            rdChk("regs held", SYS_CLK_OFS, {5'h18, 1'b0, k[1:0]});
            rdChk("second halt ignored", STATUS_OFS, {1'b0, modeOf(k[1:0]), 4'h1});
            @(posedge clk);
            wakeUp <= 1'b1;
            cyc(6);
            @(posedge clk);
            wakeUp <= 1'b0;
            cyc(2);
            check("cpu running", 8'h01, 8'(clkCtrl.cpuRun));
            rdChk("awake status", STATUS_OFS, 8'h01);
            @(posedge clk);
            wdtClearInstr <= 1'b1;
            @(posedge clk);
            wdtClearInstr <= 1'b0;
        end
        report_and_stop();
    end
endmodule
